// [design/isp_pkg.sv]
// Constants, field layout and state type of the two-wire slave serial port.
// Assumes a single system clock domain; pins are synchronised before use.

package isp_pkg;

    localparam logic [3:0] ISP_MODE_SLV7 = 4'h6;
    localparam logic [3:0] ISP_MODE_SLV10 = 4'h7;
    localparam logic [3:0] ISP_MODE_FWMST = 4'hB;
    localparam logic [3:0] ISP_MODE_SLV7_INT = 4'hE;
    localparam logic [3:0] ISP_MODE_SLV10_INT = 4'hF;

    localparam int ISP_CTL_OV = 6;
    localparam int ISP_CTL_EN = 5;
    localparam int ISP_CTL_CKP = 4;

    localparam int ISP_ST_DA = 5;
    localparam int ISP_ST_P = 4;
    localparam int ISP_ST_S = 3;
    localparam int ISP_ST_RW = 2;
    localparam int ISP_ST_UA = 1;
    localparam int ISP_ST_BF = 0;

    localparam logic [7:0] ISP_CTL_RST = 8'h00;
    localparam logic [7:0] ISP_ADR_RST = 8'h00;
    localparam logic [4:0] ISP_TEN_PREFIX = 5'h1E;
    localparam logic [3:0] ISP_BIT_LAST = 4'h8;
    localparam logic [3:0] ISP_ACK_SLOT = 4'h9;
    localparam logic [1:0] ISP_TB_HIGH = 2'h0;
    localparam logic [1:0] ISP_TB_LOW = 2'h1;
    localparam logic [1:0] ISP_TB_DONE = 2'h2;

    typedef enum logic [2:0] {
        ISP_IDLE,
        ISP_RX,
        ISP_ACK,
        ISP_TX,
        ISP_TXACK,
        ISP_SKIP
    } isp_state_t;

endpackage

// [design/isp_sync.sv]
// Two-flop synchroniser for pin levels.
// Assumes asynchronous inputs; only the second stage leaves the module.
`timescale 1ns/1ps
`default_nettype none

module isp_sync
    import isp_pkg::*;
#(
    parameter int W = 2
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] din_i,
    output logic [W-1:0] dout_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } isp_sync_t;

    isp_sync_t r_r;
    isp_sync_t r_nxt;

    always_comb
    begin
        r_nxt.meta = din_i;
        r_nxt.stab = r_r.meta;
    end

    // Idle bus level is high, so reset to high avoids a false edge
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            r_r <= '1;
        else
            r_r <= r_nxt;
    end

    assign dout_o = r_r.stab;

endmodule

`default_nettype wire

// [design/isp_slave.sv]
// Two-wire slave serial port: address match, acknowledge, buffer and stretching.
// Assumes software strobes are one-cycle pulses on clk_i; pins are open-drain.
`timescale 1ns/1ps
`default_nettype none

module isp_slave
    import isp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wdata_i,
    input wire logic addr_wr_i,
    input wire logic [7:0] addr_wdata_i,
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_wdata_i,
    input wire logic buf_rd_i,
    input wire logic irq_clr_i,
    input wire logic pin_dir_scl_i,
    input wire logic pin_dir_sda_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic [7:0] serial_port_control_o,
    output logic [7:0] serial_port_status_o,
    output logic [7:0] rx_tx_buffer_o,
    output logic [7:0] own_address_o,
    output logic port_interrupt_flag_o
);

    typedef struct packed {
        isp_state_t st;
        logic [3:0] cnt;
        logic [7:0] shf;
        logic [7:0] rbuf;
        logic [7:0] adr;
        logic [3:0] mode;
        logic ov;
        logic en;
        logic clock_release_bit;
        logic da;
        logic p;
        logic s;
        logic rw;
        logic ua;
        logic ua_pend;
        logic bf;
        logic iflag;
        logic ackd;
        logic addr_ph;
        logic [1:0] tb;
        logic scl_q;
        logic sda_q;
        logic scl_oe_n;
        logic sda_oe_n;
    } isp_regs_t;

    isp_regs_t r_r;
    isp_regs_t r_nxt;

    logic [1:0] pins_s;
    logic scl_s, sda_s, scl_rise, scl_fall;
    logic start_det, stop_det, slave_on, ten_bit;
    logic first_hit, hit, ack_ok;

    function automatic logic is_slave(input logic [3:0] m);
        is_slave = (m == ISP_MODE_SLV7) || (m == ISP_MODE_SLV10) ||
                   (m == ISP_MODE_SLV7_INT) || (m == ISP_MODE_SLV10_INT);
    endfunction

    function automatic logic has_ss_int(input logic [3:0] m);
        has_ss_int = (m == ISP_MODE_SLV7_INT) || (m == ISP_MODE_SLV10_INT) ||
                     (m == ISP_MODE_FWMST);
    endfunction

    isp_sync #(.W(2)) u_sync (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .din_i({scl_i, sda_i}),
        .dout_o(pins_s));

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign scl_rise = scl_s && !r_r.scl_q;
    assign scl_fall = !scl_s && r_r.scl_q;
    assign start_det = scl_s && r_r.scl_q && r_r.sda_q && !sda_s;
    assign stop_det = scl_s && r_r.scl_q && !r_r.sda_q && sda_s;
    assign slave_on = r_r.en && is_slave(r_r.mode);
    assign ten_bit = r_r.mode[0];

    // 10-bit first byte carries the top address bits ahead of the direction bit
    assign first_hit = (r_r.shf[7:3] == ISP_TEN_PREFIX) &&
                       (r_r.shf[2:1] == r_r.adr[2:1]);

    assign hit = !ten_bit ? (r_r.shf[7:1] == r_r.adr[7:1]) :
                 (r_r.tb == ISP_TB_LOW) ? (r_r.shf == r_r.adr) :
                 (first_hit && (!r_r.shf[0] || r_r.tb == ISP_TB_DONE));

    assign ack_ok = !r_r.bf && !r_r.ov;

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.scl_q = scl_s;
        r_nxt.sda_q = sda_s;
        if (ctrl_wr_i)
        begin
            r_nxt.ov = ctrl_wdata_i[ISP_CTL_OV];
            r_nxt.en = ctrl_wdata_i[ISP_CTL_EN];
            r_nxt.clock_release_bit = ctrl_wdata_i[ISP_CTL_CKP];
            r_nxt.mode = ctrl_wdata_i[3:0];
        end
        if (addr_wr_i)
        begin
            r_nxt.adr = addr_wdata_i;
            r_nxt.ua = 1'b0;
        end
        // Shifter is only loaded while transmitting so a receive is not corrupted
        if (buf_wr_i)
        begin
            r_nxt.rbuf = buf_wdata_i;
            if (r_r.rw)
            begin
                r_nxt.shf = buf_wdata_i;
                r_nxt.bf = 1'b1;
            end
        end
        if (buf_rd_i)
            r_nxt.bf = 1'b0;
        if (irq_clr_i)
            r_nxt.iflag = 1'b0;
        if (!r_r.en)
        begin
            r_nxt.st = ISP_IDLE;
            r_nxt.s = 1'b0;
            r_nxt.p = 1'b0;
            r_nxt.tb = ISP_TB_HIGH;
        end
        else if (start_det)
        begin
            r_nxt.s = 1'b1;
            r_nxt.p = 1'b0;
            r_nxt.iflag = r_nxt.iflag || has_ss_int(r_r.mode);
            r_nxt.st = slave_on ? ISP_RX : ISP_IDLE;
            r_nxt.cnt = 4'h0;
            r_nxt.addr_ph = 1'b1;
            if (ten_bit && r_r.tb == ISP_TB_LOW)
                r_nxt.tb = ISP_TB_HIGH;
        end
        else if (stop_det)
        begin
            r_nxt.p = 1'b1;
            r_nxt.s = 1'b0;
            r_nxt.iflag = r_nxt.iflag || has_ss_int(r_r.mode);
            r_nxt.st = ISP_IDLE;
            r_nxt.tb = ISP_TB_HIGH;
        end
        else if (slave_on)
        begin
            if (scl_rise)
                r_nxt.cnt = r_r.cnt + 4'h1;
            unique case (r_r.st)
                ISP_RX:
                begin
                    if (scl_rise)
                        r_nxt.shf = {r_r.shf[6:0], sda_s};
                    else if (scl_fall && r_r.cnt == ISP_BIT_LAST)
                    begin
                        if (!r_r.addr_ph || hit)
                        begin
                            r_nxt.st = ISP_ACK;
                            r_nxt.ackd = ack_ok;
                            r_nxt.da = !r_r.addr_ph;
                            if (ack_ok)
                            begin
                                r_nxt.rbuf = r_r.shf;
                                r_nxt.bf = 1'b1;
                            end
                            if (r_r.addr_ph)
                            begin
                                if (!ten_bit || r_r.tb != ISP_TB_LOW)
                                    r_nxt.rw = r_r.shf[0];
                                if (!ten_bit)
                                    r_nxt.addr_ph = 1'b0;
                                else if (r_r.tb == ISP_TB_LOW)
                                begin
                                    r_nxt.ua_pend = 1'b1;
                                    r_nxt.tb = ISP_TB_DONE;
                                    r_nxt.addr_ph = 1'b0;
                                end
                                else if (!r_r.shf[0])
                                begin
                                    r_nxt.ua_pend = 1'b1;
                                    r_nxt.tb = ISP_TB_LOW;
                                end
                                else
                                    r_nxt.addr_ph = 1'b0;
                            end
                        end
                        else
                            r_nxt.st = ISP_SKIP;
                    end
                end
                ISP_ACK:
                begin
                    if (scl_fall && r_r.cnt == ISP_ACK_SLOT)
                    begin
                        r_nxt.iflag = 1'b1;
                        r_nxt.cnt = 4'h0;
                        r_nxt.ua_pend = 1'b0;
                        if (r_r.ua_pend)
                            r_nxt.ua = 1'b1;
                        if (r_r.rw && !r_r.da && !r_r.addr_ph && r_r.ackd)
                        begin
                            r_nxt.st = ISP_TX;
                            r_nxt.clock_release_bit = 1'b0;
                            r_nxt.shf = r_r.rbuf;
                        end
                        else
                            r_nxt.st = ISP_RX;
                    end
                end
                ISP_TX:
                begin
                    if (scl_fall && r_r.cnt == ISP_BIT_LAST)
                        r_nxt.st = ISP_TXACK;
                    else if (scl_fall && r_r.cnt != 4'h0)
                        r_nxt.shf = {r_r.shf[6:0], 1'b0};
                end
                ISP_TXACK:
                begin
                    if (scl_rise)
                        r_nxt.ackd = !sda_s;
                    else if (scl_fall && r_r.cnt == ISP_ACK_SLOT)
                    begin
                        r_nxt.iflag = 1'b1;
                        r_nxt.cnt = 4'h0;
                        if (!r_r.ackd)
                        begin
                            r_nxt.st = ISP_IDLE;
                            r_nxt.da = 1'b0;
                            r_nxt.rw = 1'b0;
                            r_nxt.ua = 1'b0;
                            r_nxt.bf = 1'b0;
                        end
                        else
                        begin
                            r_nxt.st = ISP_TX;
                            r_nxt.da = 1'b1;
                            r_nxt.bf = 1'b0;
                            r_nxt.clock_release_bit = 1'b0;
                        end
                    end
                end
                ISP_IDLE, ISP_SKIP:
                begin
                end
            endcase
        end
        // Open-drain: only ever pull low, and only with the pin set as input
        r_nxt.sda_oe_n = !(slave_on && pin_dir_sda_i &&
                           ((r_nxt.st == ISP_ACK && r_nxt.ackd) ||
                            (r_nxt.st == ISP_TX && !r_nxt.shf[7])));
        r_nxt.scl_oe_n = !(slave_on && pin_dir_scl_i &&
                           (!r_nxt.clock_release_bit || r_nxt.ua));
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            r_r <= '0;
            r_r.st <= ISP_IDLE;
            r_r.adr <= ISP_ADR_RST;
            r_r.scl_q <= 1'b1;
            r_r.sda_q <= 1'b1;
            r_r.scl_oe_n <= 1'b1;
            r_r.sda_oe_n <= 1'b1;
        end
        else
            r_r <= r_nxt;
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n_o = r_r.scl_oe_n;
    assign sda_oe_n_o = r_r.sda_oe_n;
    assign serial_port_control_o = {1'b0, r_r.ov, r_r.en, r_r.clock_release_bit, r_r.mode};
    assign serial_port_status_o = {2'b00, r_r.da, r_r.p, r_r.s, r_r.rw, r_r.ua, r_r.bf};
    assign rx_tx_buffer_o = r_r.rbuf;
    assign own_address_o = r_r.adr;
    assign port_interrupt_flag_o = r_r.iflag;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_START_SETS_S: assert property (
        r_r.en && start_det && !ctrl_wr_i |=> r_r.s && !r_r.p)
        else $error("start not recorded");

    AST_STOP_SETS_P: assert property (
        r_r.en && stop_det && !ctrl_wr_i |=> r_r.p && !r_r.s && r_r.st == ISP_IDLE)
        else $error("stop not recorded");

    AST_SS_INT: assert property (
        r_r.en && has_ss_int(r_r.mode) && (start_det || stop_det) && !ctrl_wr_i
        |=> port_interrupt_flag_o)
        else $error("start or stop interrupt missing");

    AST_NO_ACK_WHEN_FULL: assert property (
        slave_on && !start_det && !stop_det && r_r.st == ISP_RX && scl_fall &&
        r_r.cnt == ISP_BIT_LAST && (r_r.bf || r_r.ov) && !buf_wr_i && (!r_r.addr_ph || hit)
        |=> !r_r.ackd && $stable(rx_tx_buffer_o))
        else $error("byte taken while full or overflow");

    AST_ACK_LOAD: assert property (
        slave_on && !start_det && !stop_det && r_r.st == ISP_RX && scl_fall &&
        r_r.cnt == ISP_BIT_LAST && !r_r.addr_ph && ack_ok && !buf_rd_i && !buf_wr_i
        |=> r_r.bf && rx_tx_buffer_o == $past(r_r.shf) && r_r.st == ISP_ACK)
        else $error("matched byte not loaded");

    AST_ACK_DRIVES_SDA: assert property (
        r_r.st == ISP_ACK && r_r.ackd && slave_on && pin_dir_sda_i &&
        !scl_fall && !start_det && !stop_det && !ctrl_wr_i |=> !sda_oe_n_o)
        else $error("acknowledge not driven");

    AST_OV_STABLE: assert property (
        !ctrl_wr_i |=> $stable(serial_port_control_o[ISP_CTL_OV]))
        else $error("overflow changed without write");

    AST_CKP_HOLDS_SCL: assert property (
        slave_on && pin_dir_scl_i && !r_r.clock_release_bit && !ctrl_wr_i |=> !scl_oe_n_o)
        else $error("clock not stretched");

    AST_TX_FLAG_9TH: assert property (
        slave_on && r_r.st == ISP_TXACK && scl_fall && r_r.cnt == ISP_ACK_SLOT &&
        !start_det && !stop_det |=> port_interrupt_flag_o)
        else $error("transmit flag missing");

    AST_NACK_ENDS: assert property (
        slave_on && r_r.st == ISP_TXACK && scl_fall && r_r.cnt == ISP_ACK_SLOT &&
        !r_r.ackd && !start_det && !stop_det && !buf_wr_i
        |=> r_r.st == ISP_IDLE && !serial_port_status_o[ISP_ST_RW] &&
            !serial_port_status_o[ISP_ST_BF])
        else $error("nack did not end transfer");

    AST_READ_MATCH: assert property (
        r_r.st == ISP_ACK ##1 r_r.st == ISP_TX |-> r_r.rw && !r_r.clock_release_bit)
        else $error("read match without stretch");

    AST_UA_CLEAR: assert property (
        addr_wr_i && r_r.st != ISP_ACK |=> !serial_port_status_o[ISP_ST_UA])
        else $error("address write kept update flag");

    COV_RX_ACK: cover property (r_r.st == ISP_ACK && r_r.ackd && !r_r.rw);
    COV_TX_BYTE: cover property (r_r.st == ISP_TXACK ##1 r_r.st == ISP_TX);
    COV_NACK: cover property (r_r.st == ISP_TXACK ##1 r_r.st == ISP_IDLE);
    COV_TEN_UA: cover property ($rose(r_r.ua));

endmodule

`default_nettype wire

// [test/isp_master_model.sv]
// Two-wire bus master standing on the far side of the slave port.
// Assumes open-drain wires resolved by the bench with pull-ups; 64 ns bit period.
`timescale 1ns/1ps
`default_nettype none

module isp_master_model
(
    input wire logic scl_w_i,
    input wire logic sda_w_i,
    output logic scl_drv_o,
    output logic sda_drv_o
);
    // Quarter of the bit period; the clock stands high between frames
    localparam time QTR = 16;

    initial
    begin
        scl_drv_o = 1'b1;
        sda_drv_o = 1'b1;
    end

    task automatic scl_high();
        int n;
        scl_drv_o = 1'b1;
        // Bounded so a slave that never lets go cannot hang the run
        for (n = 0; n < 4000 && scl_w_i !== 1'b1; n++)
            #1;
    endtask

    task automatic bit_io(input logic b, output logic seen);
        sda_drv_o = b;
        #QTR;
        scl_high();
        #QTR;
        seen = sda_w_i;
        #QTR;
        scl_drv_o = 1'b0;
        #QTR;
    endtask

    task automatic start_cond();
        sda_drv_o = 1'b1;
        #QTR;
        scl_high();
        #QTR;
        sda_drv_o = 1'b0;
        #QTR;
        scl_drv_o = 1'b0;
        #QTR;
    endtask

    task automatic stop_cond();
        sda_drv_o = 1'b0;
        #QTR;
        scl_high();
        #QTR;
        sda_drv_o = 1'b1;
        #QTR;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask

    task automatic recv(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(ack, s);
    endtask
endmodule

`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench: software strobes and a bus master drive the slave port.
// Assumes pull-ups on both wires; a small model tracks buffer and flags.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import isp_pkg::*;
;
    localparam logic [4:0] W_CTL = 5'h10;
    localparam logic [4:0] W_ADR = 5'h08;
    localparam logic [4:0] W_BUF = 5'h04;
    localparam logic [4:0] RD = 5'h02;
    localparam logic [4:0] CLR = 5'h01;
    logic clk = 1'b0;
    logic rst, ctrl_wr, addr_wr, buf_wr, buf_rd, irq_clr, dir_scl, dir_sda;
    logic [7:0] wd, ctl, st, buf_q, adr;
    logic scl_oe_n, sda_oe_n, scl_o, sda_o, flag, m_scl, m_sda;
    logic [7:0] exp_buf;
    logic exp_bf, exp_ov, exp_ack;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    wire logic scl_w = m_scl & (scl_oe_n | scl_o);
    wire logic sda_w = m_sda & (sda_oe_n | sda_o);

    isp_slave i_isp_slave (.clk_i(clk), .sys_rst_i(rst), .ctrl_wr_i(ctrl_wr),
        .ctrl_wdata_i(wd), .addr_wr_i(addr_wr), .addr_wdata_i(wd), .buf_wr_i(buf_wr),
        .buf_wdata_i(wd), .buf_rd_i(buf_rd), .irq_clr_i(irq_clr),
        .pin_dir_scl_i(dir_scl), .pin_dir_sda_i(dir_sda), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .serial_port_control_o(ctl), .serial_port_status_o(st), .rx_tx_buffer_o(buf_q),
        .own_address_o(adr), .port_interrupt_flag_o(flag));

    isp_master_model i_isp_master_model (.scl_w_i(scl_w), .sda_w_i(sda_w),
        .scl_drv_o(m_scl), .sda_drv_o(m_sda));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sw(input logic [4:0] s, input logic [7:0] d);
        @(negedge clk);
        {ctrl_wr, addr_wr, buf_wr, buf_rd, irq_clr} = s;
        wd = d;
        @(negedge clk);
        {ctrl_wr, addr_wr, buf_wr, buf_rd, irq_clr} = 5'h00;
        if (s[1])
            exp_bf = 1'b0;
    endtask

    // One byte from the master, checked against the buffer model
    task automatic byte_w(input logic [7:0] b, input logic hit);
        logic ack;
        sw(CLR, 8'h00);
        i_isp_master_model.send(b, ack);
        repeat (4) @(negedge clk);
        exp_ack = !(hit && !exp_bf && !exp_ov);
        if (!exp_ack)
        begin
            exp_buf = b;
            exp_bf = 1'b1;
        end
        chk(8'(ack), 8'(exp_ack));
        chk(buf_q, exp_buf);
        chk(8'(flag), 8'(hit));
        chk(8'(st[0]), 8'(exp_bf));
    endtask

    task automatic end_of_test();
        $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial
    begin
        logic [7:0] a, d, got;
        logic [3:0] md [5];
        int i;
        md = '{ISP_MODE_SLV7, ISP_MODE_SLV7_INT, ISP_MODE_SLV10_INT,
            ISP_MODE_FWMST, ISP_MODE_SLV10};
        rst = 1'b1;
        {ctrl_wr, addr_wr, buf_wr, buf_rd, irq_clr} = 5'h00;
        wd = 8'h00;
        dir_scl = 1'b1;
        dir_sda = 1'b1;
        exp_buf = 8'h00;
        exp_bf = 1'b0;
        exp_ov = 1'b0;
        void'($urandom(32'hE5D970AB));
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(ctl, 8'h00);
        chk(st, 8'h00);
        chk({scl_oe_n, sda_oe_n, flag, 5'h00}, 8'hC0);
        // Clock release low: slave modes stretch only when the pin is an input
        for (i = 0; i < 5; i++)
        begin
            dir_scl = 1'($urandom);
            sw(W_CTL, {4'h2, md[i]});
            chk(ctl, {4'h2, md[i]});
            repeat (2) @(negedge clk);
            chk(8'(scl_oe_n), 8'(!(dir_scl && md[i] != ISP_MODE_FWMST)));
        end
        dir_scl = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            sw(W_CTL, {4'h3, md[i]});
            sw(CLR, 8'h00);
            i_isp_master_model.start_cond();
            repeat (6) @(negedge clk);
            chk(8'(flag), 8'(i > 0));
            chk(st & 8'h18, 8'h08);
            sw(CLR, 8'h00);
            i_isp_master_model.stop_cond();
            repeat (6) @(negedge clk);
            chk(8'(flag), 8'(i > 0));
            chk(st & 8'h18, 8'h10);
        end
        a = {7'($urandom), 1'b0};
        sw(W_ADR, a);
        chk(adr, a);
        sw(W_CTL, 8'h36);
        i_isp_master_model.start_cond();
        byte_w(a ^ 8'h02, 1'b0);
        i_isp_master_model.start_cond();
        byte_w(a, 1'b1);
        chk(st & 8'h27, 8'h01);
        sw(RD, 8'h00);
        chk(8'(st[0]), 8'h00);
        d = 8'($urandom);
        byte_w(d, 1'b1);
        chk(st & 8'h27, 8'h21);
        byte_w(~d, 1'b1);
        sw(RD, 8'h00);
        sw(W_CTL, 8'h76);
        exp_ov = 1'b1;
        byte_w(d ^ 8'h5A, 1'b1);
        chk(8'(ctl[6]), 8'h01);
        sw(W_CTL, 8'h36);
        exp_ov = 1'b0;
        i_isp_master_model.stop_cond();
        i_isp_master_model.start_cond();
        byte_w(a | 8'h01, 1'b1);
        chk(st & 8'h07, 8'h05);
        chk(8'(scl_oe_n), 8'h00);
        sw(RD, 8'h00);
        for (i = 0; i < 2; i++)
        begin
            d = 8'($urandom);
            sw(CLR, 8'h00);
            sw(W_BUF, d);
            sw(W_CTL, 8'h36);
            i_isp_master_model.recv(i == 1, got);
            repeat (4) @(negedge clk);
            chk(got, d);
            chk(8'(flag), 8'h01);
            chk(st & 8'h07, (i == 1) ? 8'h00 : 8'h04);
        end
        i_isp_master_model.stop_cond();
        a = 8'hF0 | {5'h00, 2'($urandom), 1'b0};
        d = 8'($urandom);
        sw(W_ADR, a);
        sw(W_CTL, 8'h37);
        i_isp_master_model.start_cond();
        byte_w(a, 1'b1);
        chk(st & 8'h27, 8'h03);
        chk(8'(scl_oe_n), 8'h00);
        sw(W_ADR, d);
        sw(RD, 8'h00);
        chk(8'(scl_oe_n), 8'h01);
        byte_w(d, 1'b1);
        chk(st & 8'h27, 8'h03);
        sw(W_ADR, a);
        sw(RD, 8'h00);
        byte_w(d ^ 8'h3C, 1'b1);
        chk(st & 8'h27, 8'h21);
        i_isp_master_model.stop_cond();
        end_of_test();
    end
endmodule

`default_nettype wire
